// file: bench/tb_top.sv
// self-checking testbench for the timer control and status block
`timescale 1ns/100ps
module tb_top;
	import tcs_pkg::*;
	logic clk = 0, sys_rst = 1, soft_rst = 0, stop_req = 0, reg_wr = 0, reg_rd = 0;
	logic [1:0] reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_v, ctl;
	logic tick = 0, ovf_ack = 0, match_ack = 0, ovf_irq, match_irq;
	logic tio_in, tio_out, tio_oe, ext_lvl = 0, ext_drv = 0, inv_b, do_b;
	int failures = 0, n_tests = 0, seed = 32'h1bf1, cycles = 0, m, k;
	// reference model of the counter and match flag, kept from the rules
	int mdl_cnt = 0, mdl_load = 0, mdl_cmp = 0;
	bit mdl_first = 0, mdl_trm = 0, mdl_run = 0, mdl_mf = 0;
	always #10 clk = ~clk;
	tcs_timer_ctrl tcs_timer_ctrl_i (.CLK(clk), .SYS_RST(sys_rst), .SOFT_RST(soft_rst),
		.STOP_REQ(stop_req), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .PRESCALE_TICK(tick),
		.OVF_ACK(ovf_ack), .MATCH_ACK(match_ack), .OVF_IRQ(ovf_irq),
		.MATCH_IRQ(match_irq), .TIO_IN(tio_in), .TIO_OUT(tio_out), .TIO_OE(tio_oe));
	tcs_pin_model tcs_pin_model_i (.TIO_OUT(tio_out), .TIO_OE(tio_oe), .EXT_LVL(ext_lvl),
		.EXT_DRV(ext_drv), .TIO_IN(tio_in));
	// ********
	// helpers
	// ********
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			end_sim();
		end
	end
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic mdl_write(input logic [1:0] a, input logic [15:0] d);
		if (a == OFS_LOAD) begin
			mdl_load = d;
		end else if (a == OFS_COMPARE) begin
			mdl_cmp = d;
		end else if (a == OFS_CTRL_STATUS) begin
			if (d[BIT_RUN] && !mdl_run) begin
				mdl_cnt = 0;
				mdl_first = 1;
			end
			if (d[BIT_MF] || !d[BIT_RUN])
				mdl_mf = 0;
			mdl_run = d[BIT_RUN];
			mdl_trm = d[BIT_TRM];
		end
	endtask
	task automatic mdl_event();
		if (mdl_run) begin
			if (mdl_first || (mdl_trm && mdl_cnt == mdl_cmp)) begin
				mdl_cnt = mdl_load;
				mdl_first = 0;
			end else begin
				mdl_cnt = (mdl_cnt + 1) % 65536;
			end
			if (mdl_cnt == mdl_cmp)
				mdl_mf = 1;
		end
	endtask
	// strobe dropped by nonblocking update on the edge, so back to back calls never collide
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge clk);
		reg_wr <= 0;
		#1;
		mdl_write(a, d);
	endtask
	task automatic rd(input logic [1:0] a);
		reg_addr = a;
		reg_rd = 1;
		@(posedge clk);
		reg_rd <= 0;
		#1;
		cyc(1);
		rd_v = reg_rdata;
	endtask
	// prescaler events spaced well apart so each is seen alone
	task automatic tick_n(input int c);
		repeat (c) begin
			tick = 1;
			cyc(1);
			tick = 0;
			mdl_event();
			cyc(3);
		end
	endtask
	function automatic logic out_mode(input int md);
		return md inside {1, 2, 7, 9, 10, 15};
	endfunction
	// ********
	// scenarios
	// ********
	initial begin
		cyc(2);
		sys_rst = 0;
		rd(OFS_CTRL_STATUS);
		chk_word(rd_v, RST_WORD);
		{inv_b, do_b} = 2'($random(seed));
		ctl = 16'h0000;
		ctl[BIT_DIR] = 1'b1;
		ctl[BIT_INV] = inv_b;
		ctl[BIT_DO] = do_b;
		wr(OFS_CTRL_STATUS, ctl);
		cyc(2);
		chk_bit(tio_oe, 1'b1);
		chk_bit(tio_out, do_b ^ inv_b);
		ctl[BIT_DIR] = 1'b0;
		ext_drv = 1;
		ext_lvl = 1'($random(seed));
		wr(OFS_CTRL_STATUS, ctl);
		cyc(4);
		chk_bit(tio_oe, 1'b0);
		rd(OFS_CTRL_STATUS);
		chk_bit(rd_v[BIT_DI], ext_lvl ^ inv_b);
		ext_drv = 0;
		for (int md = 0; md < 16; md++) begin
			ctl = 16'h0000;
			ctl[7:4] = md[3:0];
			wr(OFS_CTRL_STATUS, ctl);
			ctl[BIT_RUN] = 1'b1;
			wr(OFS_CTRL_STATUS, ctl);
			cyc(2);
			chk_bit(tio_oe, out_mode(md));
			rd(OFS_CTRL_STATUS);
			chk_word(rd_v & 16'h00F1, ctl & 16'h00F1);
			wr(OFS_CTRL_STATUS, 16'h0000);
		end
		k = ($random(seed) & 7) + 2;
		m = $random(seed) & 16'h7FFF;
		wr(OFS_LOAD, 16'(m));
		wr(OFS_COMPARE, 16'(m + k - 1));
		ctl = 16'h0000;
		ctl[BIT_PCE] = 1'b1;
		ctl[BIT_MIE] = 1'b1;
		ctl[BIT_TRM] = 1'b1;
		wr(OFS_CTRL_STATUS, ctl);
		ctl[BIT_RUN] = 1'b1;
		wr(OFS_CTRL_STATUS, ctl);
		tick_n(k - 1);
		chk_bit(match_irq, 1'b0);
		rd(OFS_COUNT);
		chk_word(rd_v, 16'(m + k - 2));
		chk_word(rd_v, 16'(mdl_cnt));
		tick_n(1);
		chk_bit(match_irq, 1'b1);
		chk_bit(match_irq, mdl_mf);
		tick_n(1);
		rd(OFS_COUNT);
		chk_word(rd_v, 16'(m));
		chk_word(rd_v, 16'(mdl_cnt));
		wr(OFS_CTRL_STATUS, ctl);
		cyc(1);
		chk_bit(match_irq, 1'b1);
		ctl[BIT_MIE] = 1'b0;
		wr(OFS_CTRL_STATUS, ctl);
		cyc(1);
		chk_bit(match_irq, 1'b0);
		rd(OFS_CTRL_STATUS);
		chk_bit(rd_v[BIT_MF], 1'b1);
		ctl[BIT_MF] = 1'b1;
		wr(OFS_CTRL_STATUS, ctl);
		rd(OFS_CTRL_STATUS);
		chk_bit(rd_v[BIT_MF], 1'b0);
		tick_n(k - 1);
		rd(OFS_CTRL_STATUS);
		chk_bit(rd_v[BIT_MF], mdl_mf);
		match_ack = 1;
		cyc(1);
		match_ack = 0;
		mdl_mf = 0;
		rd(OFS_CTRL_STATUS);
		chk_bit(rd_v[BIT_MF], 1'b0);
		wr(OFS_LOAD, 16'hFFFE);
		wr(OFS_COMPARE, 16'h0005);
		ctl = 16'h0000;
		ctl[BIT_PCE] = 1'b1;
		ctl[BIT_OVIE] = 1'b1;
		wr(OFS_CTRL_STATUS, ctl);
		for (int c = 0; c < 3; c++) begin
			ctl[BIT_RUN] = 1'b1;
			wr(OFS_CTRL_STATUS, ctl);
			tick_n(2);
			chk_bit(ovf_irq, 1'b0);
			tick_n(1);
			chk_bit(ovf_irq, 1'b1);
			rd(OFS_COUNT);
			chk_word(rd_v, 16'h0000);
			chk_word(rd_v, 16'(mdl_cnt));
			ovf_ack = (c == 0);
			stop_req = (c == 1);
			ctl[BIT_RUN] = 1'b0;
			if (c == 2)
				wr(OFS_CTRL_STATUS, ctl);
			else
				cyc(1);
			ovf_ack = 0;
			stop_req = 0;
			cyc(1);
			chk_bit(ovf_irq, 1'b0);
			wr(OFS_CTRL_STATUS, ctl);
		end
		// five toggles from idle: three active edges, two of the other kind
		ext_drv = 1;
		wr(OFS_LOAD, 16'h0010);
		for (int iv = 0; iv < 2; iv++) begin
			ext_lvl = iv[0];
			ctl = 16'h0000;
			ctl[7:4] = MODE_EVENT;
			ctl[BIT_INV] = iv[0];
			wr(OFS_CTRL_STATUS, ctl);
			cyc(4);
			ctl[BIT_RUN] = 1'b1;
			wr(OFS_CTRL_STATUS, ctl);
			repeat (5) begin
				ext_lvl = ~ext_lvl;
				if (ext_lvl != iv[0])
					mdl_event();
				cyc(4);
			end
			cyc(4);
			rd(OFS_COUNT);
			chk_word(rd_v, 16'h0012);
			chk_word(rd_v, 16'(mdl_cnt));
			wr(OFS_CTRL_STATUS, 16'h0000);
		end
		// width measurement: preload on the active edge, three ticks, capture on the end edge
		wr(OFS_LOAD, 16'h0020);
		ext_lvl = inv_b;
		ctl = 16'h0000;
		ctl[7:4] = MODE_WIDTH;
		ctl[BIT_INV] = inv_b;
		ctl[BIT_PCE] = 1'b1;
		ctl[BIT_TRM] = 1'b1;
		wr(OFS_CTRL_STATUS, ctl);
		cyc(4);
		ctl[BIT_RUN] = 1'b1;
		wr(OFS_CTRL_STATUS, ctl);
		ext_lvl = ~inv_b;
		cyc(4);
		tick_n(3);
		ext_lvl = inv_b;
		cyc(4);
		rd(OFS_COUNT);
		chk_word(rd_v, 16'h0023);
		rd(OFS_CTRL_STATUS);
		chk_bit(rd_v[BIT_MF], 1'b1);
		wr(OFS_CTRL_STATUS, 16'h0000);
		ext_drv = 0;
		wr(OFS_CTRL_STATUS, 16'h8776);
		soft_rst = 1;
		cyc(1);
		soft_rst = 0;
		rd(OFS_CTRL_STATUS);
		chk_word(rd_v, RST_WORD);
		end_sim();
	end
endmodule

// file: bench/tcs_pin_model.sv
// far-side model of the timer pin: external source or load
`timescale 1ns/100ps
module tcs_pin_model (
	input wire logic TIO_OUT,
	input wire logic TIO_OE,
	input wire logic EXT_LVL,
	input wire logic EXT_DRV,
	output logic TIO_IN
);
	// ********
	// pin level
	// ********
	// pull-down when nobody drives, so a released pin never keeps a stale value
	assign TIO_IN = TIO_OE ? TIO_OUT : (EXT_DRV ? EXT_LVL : 1'b0);
endmodule

// file: logic/tcs_pkg.sv
// constants for the timer control and status block
package tcs_pkg;
	// ****************************************
	// register word offsets
	// ****************************************
	localparam logic [1:0] OFS_CTRL_STATUS = 2'h0;
	localparam logic [1:0] OFS_LOAD = 2'h1;
	localparam logic [1:0] OFS_COMPARE = 2'h2;
	localparam logic [1:0] OFS_COUNT = 2'h3;
	// ****************************************
	// control and status field positions
	// ****************************************
	localparam int BIT_RUN = 0;
	localparam int BIT_OVIE = 1;
	localparam int BIT_MIE = 2;
	localparam int BIT_MODE_LO = 4;
	localparam int BIT_INV = 8;
	localparam int BIT_TRM = 9;
	localparam int BIT_DIR = 10;
	localparam int BIT_DI = 11;
	localparam int BIT_DO = 12;
	localparam int BIT_OVF = 13;
	localparam int BIT_MF = 14;
	localparam int BIT_PCE = 15;
	// ****************************************
	// mode codes
	// ****************************************
	localparam logic [3:0] MODE_GPIO = 4'h0;
	localparam logic [3:0] MODE_PULSE = 4'h1;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_EVENT = 4'h3;
	localparam logic [3:0] MODE_WIDTH = 4'h4;
	localparam logic [3:0] MODE_PERIOD = 4'h5;
	localparam logic [3:0] MODE_CAPTURE = 4'h6;
	localparam logic [3:0] MODE_PWM = 4'h7;
	localparam logic [3:0] MODE_WDG_PULSE = 4'h9;
	localparam logic [3:0] MODE_WDG_TOGGLE = 4'hA;
	localparam logic [3:0] MODE_TMR_PULSE = 4'hF;
	// ****************************************
	// reset values and count limits
	// ****************************************
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [3:0] RST_MODE = 4'h0;
	localparam logic RST_BIT = 1'b0;
	localparam logic [15:0] CNT_TOP = 16'hFFFF;
	localparam logic [15:0] CNT_ONE = 16'h0001;
endpackage

// file: logic/tcs_timer_ctrl.sv
// control, status, counter and pin logic for one timer channel
`timescale 1ns/100ps
module tcs_timer_ctrl
	import tcs_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic SOFT_RST,
	input wire logic STOP_REQ,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [1:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	input wire logic PRESCALE_TICK,
	input wire logic OVF_ACK,
	input wire logic MATCH_ACK,
	output logic OVF_IRQ,
	output logic MATCH_IRQ,
	input wire logic TIO_IN,
	output logic TIO_OUT,
	output logic TIO_OE
);
	// ****************************************
	// state
	// ****************************************
	logic run_r, ovie_r, mie_r, inv_r, trm_r, dir_r, do_r, pce_r, ovf_r, mf_r;
	logic [3:0] mode_r;
	logic [15:0] cnt_r, load_r, cmp_r, cap_r;
	logic first_r, div_r, pulse_r, tog_r;
	logic tio_s1_r, tio_s2_r, tio_d_r;
	logic [15:0] cnt_nxt;
	logic ovf_set, mf_set;

	// ****************************************
	// register decode
	// ****************************************
	wire wr_csr = REG_WR && (REG_ADDR == OFS_CTRL_STATUS);
	wire wr_load = REG_WR && (REG_ADDR == OFS_LOAD);
	wire wr_cmp = REG_WR && (REG_ADDR == OFS_COMPARE);
	wire run_nxt = wr_csr ? REG_WDATA[BIT_RUN] : run_r;
	wire run_rise = run_nxt && !run_r;
	wire ovie_nxt = wr_csr ? REG_WDATA[BIT_OVIE] : ovie_r;
	wire mie_nxt = wr_csr ? REG_WDATA[BIT_MIE] : mie_r;

	// ****************************************
	// mode decode
	// ****************************************
	wire md_gpio = (mode_r == MODE_GPIO);
	wire md_pulse = (mode_r == MODE_PULSE) || (mode_r == MODE_WDG_PULSE)
		|| (mode_r == MODE_TMR_PULSE);
	wire md_toggle = (mode_r == MODE_TOGGLE) || (mode_r == MODE_WDG_TOGGLE)
		|| (mode_r == MODE_PWM);
	wire md_wdg = (mode_r == MODE_WDG_PULSE) || (mode_r == MODE_WDG_TOGGLE);
	wire md_pwm = (mode_r == MODE_PWM);
	wire md_event = (mode_r == MODE_EVENT);
	wire md_width = (mode_r == MODE_WIDTH);
	wire md_period = (mode_r == MODE_PERIOD);
	wire md_capture = (mode_r == MODE_CAPTURE);
	wire md_meas = md_width || md_period || md_capture;
	// reserved codes fall out of every group and leave the counter idle
	wire md_cmp = md_gpio || md_pulse || md_toggle || md_event;

	// ****************************************
	// pin sampling and event selection
	// ****************************************
	wire pin_lvl = tio_s2_r ^ inv_r;
	wire rise_raw = tio_s2_r && !tio_d_r;
	wire fall_raw = !tio_s2_r && tio_d_r;
	// active edge starts the active level; end edge closes it
	wire act_edge = inv_r ? fall_raw : rise_raw;
	wire end_edge = inv_r ? rise_raw : fall_raw;
	// prescaler tick is taken as given, the invert bit never touches it
	wire src_tick = pce_r ? PRESCALE_TICK : div_r;
	wire evt = run_r && md_cmp && ((md_event && !pce_r) ? act_edge : src_tick);
	wire hit_cmp = (md_cmp && !md_pwm) && (cnt_r == cmp_r);
	wire hit_top = md_pwm && (cnt_r == CNT_TOP);
	wire reload_hit = trm_r && (hit_cmp || hit_top);
	// measurement: counting gate and capture/preload edges
	wire m_inc = run_r && md_meas && src_tick && (!md_width || pin_lvl);
	wire m_done = run_r && ((md_width && end_edge) || ((md_period || md_capture) && act_edge));
	wire m_load = run_r && md_meas && trm_r && act_edge;
	wire wdg_kick = run_r && md_wdg && wr_load;

	// ****************************************
	// counter next value
	// ****************************************
	always_comb begin
		cnt_nxt = cnt_r;
		ovf_set = 1'b0;
		mf_set = 1'b0;
		if (run_rise) begin
			cnt_nxt = RST_WORD;
		end else if (wdg_kick) begin
			cnt_nxt = REG_WDATA;
		end else if (md_meas) begin
			mf_set = m_done;
			if (m_load) begin
				cnt_nxt = load_r;
			end else if (m_inc) begin
				cnt_nxt = cnt_r + CNT_ONE;
				ovf_set = (cnt_r == CNT_TOP);
			end
		end else if (evt) begin
			if (first_r || reload_hit) begin
				cnt_nxt = load_r;
			end else begin
				cnt_nxt = cnt_r + CNT_ONE;
				ovf_set = (cnt_r == CNT_TOP);
			end
			mf_set = (cnt_nxt == cmp_r);
		end
	end

	// flags: a set in the same cycle as a clear wins
	wire ovf_clr = (wr_csr && REG_WDATA[BIT_OVF]) || OVF_ACK || STOP_REQ || !run_r;
	wire mf_clr = (wr_csr && REG_WDATA[BIT_MF]) || MATCH_ACK || STOP_REQ || !run_r;
	wire ovf_nxt = ovf_set || (ovf_r && !ovf_clr);
	wire mf_nxt = mf_set || (mf_r && !mf_clr);

	// ****************************************
	// pin drive
	// ****************************************
	wire gpio_oe = md_gpio && dir_r;
	wire out_mode = run_r && (md_pulse || md_toggle);
	wire oe_nxt = gpio_oe || out_mode;
	wire out_nxt = gpio_oe ? (do_r ^ inv_r) : ((md_pulse ? pulse_r : tog_r) ^ inv_r);

	// ****************************************
	// read data
	// ****************************************
	wire [15:0] csr_word = {pce_r, mf_r, ovf_r, do_r, pin_lvl, dir_r, trm_r, inv_r,
		mode_r, 1'b0, mie_r, ovie_r, run_r};
	wire [15:0] rd_word = (REG_ADDR == OFS_CTRL_STATUS) ? csr_word :
		(REG_ADDR == OFS_COMPARE) ? cmp_r :
		(REG_ADDR == OFS_COUNT) ? (md_meas ? cap_r : cnt_r) : RST_WORD;

	// ****************************************
	// control register
	// ****************************************
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			{run_r, ovie_r, mie_r, inv_r, trm_r, dir_r, do_r, pce_r} <= 8'h00;
			mode_r <= RST_MODE;
		end else if (SOFT_RST) begin
			{run_r, ovie_r, mie_r, inv_r, trm_r, dir_r, do_r, pce_r} <= 8'h00;
			mode_r <= RST_MODE;
		end else if (wr_csr) begin
			run_r <= REG_WDATA[BIT_RUN];
			ovie_r <= REG_WDATA[BIT_OVIE];
			mie_r <= REG_WDATA[BIT_MIE];
			mode_r <= REG_WDATA[BIT_MODE_LO +: 4];
			inv_r <= REG_WDATA[BIT_INV];
			trm_r <= REG_WDATA[BIT_TRM];
			dir_r <= REG_WDATA[BIT_DIR];
			pce_r <= REG_WDATA[BIT_PCE];
			if (md_gpio) begin
				do_r <= REG_WDATA[BIT_DO];
			end
		end
	end

	// ****************************************
	// data registers and counter
	// ****************************************
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			{load_r, cmp_r, cnt_r, cap_r} <= {4{RST_WORD}};
			{first_r, div_r, pulse_r, tog_r, ovf_r, mf_r} <= 6'h00;
		end else if (SOFT_RST) begin
			{load_r, cmp_r, cnt_r, cap_r} <= {4{RST_WORD}};
			{first_r, div_r, pulse_r, tog_r, ovf_r, mf_r} <= 6'h00;
		end else begin
			if (wr_load) begin
				load_r <= REG_WDATA;
			end
			if (wr_cmp) begin
				cmp_r <= REG_WDATA;
			end
			cnt_r <= cnt_nxt;
			ovf_r <= ovf_nxt;
			mf_r <= mf_nxt;
			div_r <= run_r && !div_r;
			if (run_rise) begin
				first_r <= 1'b1;
			end else if (evt) begin
				first_r <= 1'b0;
			end
			if (m_done) begin
				cap_r <= cnt_r;
			end
			// pulse lasts one timer clock; toggle starts from the idle level
			if (run_rise) begin
				{pulse_r, tog_r} <= 2'b00;
			end else if (evt) begin
				pulse_r <= mf_set;
				tog_r <= tog_r ^ (mf_set || (md_pwm && ovf_set));
			end
		end
	end

	// ****************************************
	// pin synchroniser and outputs
	// ****************************************
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			{tio_s1_r, tio_s2_r, tio_d_r} <= 3'b000;
			{TIO_OUT, TIO_OE, OVF_IRQ, MATCH_IRQ} <= 4'h0;
			REG_RDATA <= RST_WORD;
		end else begin
			tio_s1_r <= TIO_IN;
			tio_s2_r <= tio_s1_r;
			tio_d_r <= tio_s2_r;
			TIO_OUT <= out_nxt;
			TIO_OE <= oe_nxt && !SOFT_RST;
			OVF_IRQ <= ovf_nxt && ovie_nxt && !SOFT_RST;
			MATCH_IRQ <= mf_nxt && mie_nxt && !SOFT_RST;
			if (REG_RD) begin
				REG_RDATA <= rd_word;
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_enable;
		!run_r ##1 run_r;
	endsequence
	sequence s_wrap;
		evt && !first_r && !reload_hit && cnt_r == CNT_TOP && !SOFT_RST && !wdg_kick;
	endsequence
	a_ovf_irq_gate: assert property (OVF_IRQ == (ovf_r && ovie_r))
		else $error("overflow irq not flag and enable");
	a_match_irq_gate: assert property (MATCH_IRQ == (mf_r && mie_r))
		else $error("match irq not flag and enable");
	a_wrap_sets_ovf: assert property (s_wrap |=> ovf_r && cnt_r == RST_WORD)
		else $error("wrap did not set overflow flag");
	a_enable_clears: assert property (s_enable |-> cnt_r == RST_WORD && first_r)
		else $error("enable did not clear the count");
	a_first_load: assert property (evt && first_r && !SOFT_RST && !wdg_kick
		|=> cnt_r == $past(load_r)) else $error("first event did not load");
	a_free_run: assert property (evt && !first_r && !trm_r && !SOFT_RST && !wdg_kick
		|=> cnt_r == $past(cnt_r) + CNT_ONE) else $error("free run count wrong");
	a_match_flag: assert property (evt && !first_r && !reload_hit && !SOFT_RST
		&& !wdg_kick && (cnt_r + CNT_ONE) == cmp_r |=> mf_r) else $error("match flag not set");
	a_ovf_w1c: assert property (wr_csr && REG_WDATA[BIT_OVF] && !ovf_set
		|=> !ovf_r) else $error("overflow flag not cleared by write one");
	a_mf_stop: assert property (STOP_REQ && !mf_set |=> !mf_r)
		else $error("match flag survived stop");
	a_gpio_drive: assert property (md_gpio && dir_r && !SOFT_RST
		|=> TIO_OE && TIO_OUT == $past(do_r ^ inv_r)) else $error("gpio output wrong");
	a_di_read: assert property (REG_RD && REG_ADDR == OFS_CTRL_STATUS
		|=> REG_RDATA[BIT_DI] == $past(tio_s2_r ^ inv_r)) else $error("input data bit wrong");
	a_soft_reset: assert property (SOFT_RST |=> !run_r && mode_r == RST_MODE
		&& !inv_r && !pce_r && !dir_r && !do_r && !trm_r) else $error("soft reset left bits");
	// ****************************************
	// measurement, clock source, pin, flag and register checks
	// ****************************************
	sequence s_meas_edge;
		run_r && md_meas && act_edge && !SOFT_RST;
	endsequence
	sequence s_width_end;
		run_r && md_width && end_edge && !SOFT_RST;
	endsequence
	sequence s_period_end;
		run_r && (md_period || md_capture) && act_edge && !SOFT_RST;
	endsequence
	a_meas_preload: assert property (s_meas_edge ##0 trm_r
		|=> cnt_r == $past(load_r)) else $error("measurement edge did not preload");
	a_width_capture: assert property (s_width_end
		|=> cap_r == $past(cnt_r) && mf_r) else $error("width end not captured");
	a_period_capture: assert property (s_period_end
		|=> cap_r == $past(cnt_r) && mf_r) else $error("period edge not captured");
	a_width_gate: assert property (run_r && md_width && !pin_lvl && !SOFT_RST
		|=> cnt_r == $past(cnt_r)) else $error("width counted outside active level");
	a_width_count: assert property (run_r && md_width && pin_lvl && src_tick
		&& !act_edge && !SOFT_RST |=> cnt_r == $past(cnt_r) + CNT_ONE) else $error("width tick lost");
	a_tick_select: assert property (run_r && md_cmp && pce_r |-> evt == PRESCALE_TICK)
		else $error("prescaled source not used");
	a_half_clock: assert property (run_r && md_cmp && !pce_r && !md_event |-> evt == div_r)
		else $error("internal half rate not used");
	a_div_rate: assert property (run_r && div_r |=> !div_r)
		else $error("half rate divider stuck");
	a_pin_event: assert property (run_r && md_event && !pce_r
		|-> evt == (inv_r ? fall_raw : rise_raw)) else $error("wrong pin edge counted");
	a_pin_sync: assert property (tio_s1_r == $past(TIO_IN) && tio_s2_r == $past(tio_s1_r))
		else $error("pin synchroniser broken");
	a_prescale_no_inv: assert property (run_r && md_event && pce_r && inv_r
		|-> evt == PRESCALE_TICK) else $error("invert touched prescaled source");
	a_reserved_idle: assert property (run_r && !md_cmp && !md_meas
		|-> !evt && !m_inc && !m_done) else $error("reserved mode not idle");
	a_input_no_drive: assert property (!md_gpio && !md_pulse && !md_toggle
		|=> !TIO_OE) else $error("pin driven in input mode");
	a_out_level: assert property (run_r && (md_pulse || md_toggle) && !SOFT_RST
		|=> TIO_OE && TIO_OUT == $past((md_pulse ? pulse_r : tog_r) ^ inv_r)) else $error("out level");
	a_out_start: assert property (s_enable |-> !tog_r && !pulse_r)
		else $error("output not idle after enable");
	a_ovf_ack: assert property (OVF_ACK && !ovf_set |=> !ovf_r)
		else $error("overflow flag survived acknowledge");
	a_mf_ack: assert property (MATCH_ACK && !mf_set |=> !mf_r)
		else $error("match flag survived acknowledge");
	a_mf_w1c: assert property (wr_csr && REG_WDATA[BIT_MF] && !mf_set |=> !mf_r)
		else $error("match flag not cleared by write one");
	a_ovf_stop: assert property (STOP_REQ && !ovf_set |=> !ovf_r)
		else $error("overflow flag survived stop");
	a_flags_off: assert property (!run_r |=> !ovf_r && !mf_r)
		else $error("flag set while disabled");
	a_w0_keeps: assert property (wr_csr && !REG_WDATA[BIT_OVF] && REG_WDATA[BIT_RUN]
		&& run_r && ovf_r && !OVF_ACK && !STOP_REQ && !SOFT_RST
		|=> ovf_r) else $error("write zero cleared overflow flag");
	a_do_ignored: assert property (wr_csr && !md_gpio && !SOFT_RST
		|=> do_r == $past(do_r)) else $error("output data written outside gpio");
	a_mode_write: assert property (wr_csr && !SOFT_RST
		|=> mode_r == $past(REG_WDATA[BIT_MODE_LO +: 4])) else $error("mode field not written");
	a_count_read: assert property (REG_RD && REG_ADDR == OFS_COUNT && !md_meas
		|=> REG_RDATA == $past(cnt_r)) else $error("count read wrong");
endmodule
